// ---- logic/vlef_top.sv ----
// VLAN entry egress filter: AHB-Lite register slave, table ops, frame egress decision.
// Assumes a single AHB-Lite master and a forwarding pipeline synchronous to the core clock.
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "vlef_defs.svh"
module vlef_top (
    input wire logic CORE_CLK_IN,          // Core clock, 20 MHz
    input wire logic RST_B_IN,             // Async reset, active low
    input wire logic HSEL_IN,              // AHB select
    input wire logic [31:0] HADDR_IN,      // AHB address
    input wire logic [1:0] HTRANS_IN,      // AHB transfer type
    input wire logic HWRITE_IN,            // AHB write
    input wire logic [2:0] HSIZE_IN,       // AHB size, word only
    input wire logic [31:0] HWDATA_IN,     // AHB write data
    input wire logic HREADY_IN,            // AHB ready
    output logic [31:0] HRDATA_OUT,        // AHB read data
    output logic HREADYOUT_OUT,            // AHB slave ready
    output logic HRESP_OUT,                // AHB response, always OKAY
    input wire logic FRM_VALID_IN,         // Frame lookup request
    input wire logic [11:0] FRM_VID_IN,    // Frame VLAN id
    input wire logic FRM_TAGGED_IN,        // Frame carries a VLAN tag
    input wire logic [8:0] FRM_LOOKUP_MAP_IN, // Address lookup destination map
    input wire logic [3:0] FRM_INGRESS_IN, // Ingress port number
    output logic FRM_RESULT_VALID_OUT,     // Result pulse, two cycles after request
    output logic [8:0] FRM_EGRESS_MAP_OUT, // Allowed egress ports
    output logic [8:0] FRM_STRIP_MAP_OUT,  // Ports that strip the tag
    output logic [2:0] FRM_STP_SEL_OUT,    // Spanning tree instance
    output logic FRM_METER_EN_OUT,         // Ingress policing enabled
    output logic FRM_METER_BKT_OUT         // Policing bucket
);
    vlef_pkg::vlef_regs_t r;
    vlef_pkg::vlef_regs_t next_r;
    logic tbl_we;
    logic [11:0] tbl_addr;
    logic [23:0] tbl_a_rdata;
    logic [23:0] tbl_b_rdata;
    logic busy;
    logic sw_wr;
    logic [8:0] member;
    logic [8:0] strip;
    logic [8:0] ing_bit;

    vlef_table u_table (
        .clk_in(CORE_CLK_IN),
        .rst_b_in(RST_B_IN),
        .a_we_in(tbl_we),
        .a_addr_in(tbl_addr),
        .a_wdata_in(r.st == vlef_pkg::VLEF_CLEAR ? `VLEF_ENTRY_RESET : r.entry),
        .a_rdata_out(tbl_a_rdata),
        .b_addr_in(FRM_VID_IN),
        .b_rdata_out(tbl_b_rdata)
    );

    assign busy = r.start || (r.st != vlef_pkg::VLEF_IDLE);
    assign sw_wr = r.ap_valid && r.ap_write && r.ap_hit && !busy;
    assign tbl_addr = (r.st == vlef_pkg::VLEF_CLEAR) ? r.clr_idx : r.index;
    assign tbl_we = (r.st == vlef_pkg::VLEF_CLEAR) ||
        (r.st == vlef_pkg::VLEF_IDLE && r.start && r.op == `VLEF_OP_WRITE);
    assign member = tbl_b_rdata[`VLEF_ENT_MEMBER_HI:`VLEF_ENT_MEMBER_LO] & `VLEF_PORT_VALID;
    assign strip = tbl_b_rdata[`VLEF_ENT_STRIP_HI:`VLEF_ENT_STRIP_LO] & `VLEF_PORT_VALID;
    assign ing_bit = 9'(9'h001 << r.f1_ingress);

    always_comb begin
        next_r = r;
        // Address phase capture
        next_r.ap_valid = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
        next_r.ap_write = HWRITE_IN;
        next_r.ap_idx = HADDR_IN[9:2];
        next_r.ap_hit = (HADDR_IN[31:10] == 22'h000000) && (HADDR_IN[1:0] == 2'h0) &&
            (HADDR_IN[9:2] == `VLEF_IDX_OP || HADDR_IN[9:2] == `VLEF_IDX_INDEX ||
             HADDR_IN[9:2] == `VLEF_IDX_ENTRY || HADDR_IN[9:2] == `VLEF_IDX_CTRL);
        // Data phase register writes; ignored while a table op runs
        if (sw_wr) begin
            case (r.ap_idx)
                `VLEF_IDX_OP: begin
                    next_r.op = HWDATA_IN[1:0];
                    next_r.start = HWDATA_IN[`VLEF_OP_START_BIT];
                end
                `VLEF_IDX_INDEX: begin
                    next_r.index = HWDATA_IN[11:0];
                end
                `VLEF_IDX_ENTRY: begin
                    next_r.entry = HWDATA_IN[23:0];
                end
                `VLEF_IDX_CTRL: begin
                    next_r.dot1q_en = HWDATA_IN[0];
                end
                default: begin
                end
            endcase
        end
        // Table operation sequencer
        case (r.st)
            vlef_pkg::VLEF_IDLE: begin
                if (r.start) begin
                    case (r.op)
                        `VLEF_OP_WRITE: begin
                            next_r.start = 1'b0;
                        end
                        `VLEF_OP_READ: begin
                            next_r.st = vlef_pkg::VLEF_RDWAIT;
                        end
                        `VLEF_OP_CLEAR: begin
                            next_r.st = vlef_pkg::VLEF_CLEAR;
                            next_r.clr_idx = 12'h000;
                        end
                        default: begin
                            next_r.start = 1'b0;
                        end
                    endcase
                end
            end
            vlef_pkg::VLEF_RDWAIT: begin
                next_r.entry = tbl_a_rdata;
                next_r.start = 1'b0;
                next_r.st = vlef_pkg::VLEF_IDLE;
            end
            vlef_pkg::VLEF_CLEAR: begin
                next_r.clr_idx = r.clr_idx + 12'h001;
                if (r.clr_idx == `VLEF_TBL_LAST) begin
                    next_r.start = 1'b0;
                    next_r.st = vlef_pkg::VLEF_IDLE;
                end
            end
            default: begin
                next_r.st = vlef_pkg::VLEF_IDLE;
                next_r.start = 1'b0;
            end
        endcase
        // Frame stage 1: table read under way
        next_r.f1_valid = FRM_VALID_IN;
        if (FRM_VALID_IN) begin
            next_r.f1_tagged = FRM_TAGGED_IN;
            next_r.f1_lookup = FRM_LOOKUP_MAP_IN & `VLEF_PORT_VALID;
            next_r.f1_ingress = FRM_INGRESS_IN;
        end
        // Frame stage 2: egress decision
        next_r.res_valid = r.f1_valid;
        if (r.f1_valid) begin
            next_r.res_tagged = r.f1_tagged;
            next_r.res_member = member;
            next_r.res_stp = tbl_b_rdata[`VLEF_ENT_STP_HI:`VLEF_ENT_STP_LO];
            next_r.res_meter_en = tbl_b_rdata[`VLEF_ENT_METER_BIT];
            next_r.res_meter_bkt = tbl_b_rdata[`VLEF_ENT_METER_BIT] &&
                tbl_b_rdata[`VLEF_ENT_BKT_BIT];
            if (!r.f1_tagged) begin
                next_r.res_egress = r.f1_lookup;
                next_r.res_strip = 9'h000;
            end else begin
                if (tbl_b_rdata[`VLEF_ENT_BASIS_BIT]) begin
                    next_r.res_egress = member & ~ing_bit;
                end else begin
                    next_r.res_egress = r.f1_lookup & member;
                end
                next_r.res_strip = strip & next_r.res_egress;
                if (r.dot1q_en) begin
                    next_r.res_strip[`VLEF_MGMT_BIT] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    always_comb begin
        HRDATA_OUT = 32'h00000000;
        if (r.ap_valid && !r.ap_write && r.ap_hit) begin
            case (r.ap_idx)
                `VLEF_IDX_OP: HRDATA_OUT = {24'h000000, busy, 5'h00, r.op};
                `VLEF_IDX_INDEX: HRDATA_OUT = {20'h00000, r.index};
                `VLEF_IDX_ENTRY: HRDATA_OUT = {8'h00, r.entry};
                `VLEF_IDX_CTRL: HRDATA_OUT = {31'h00000000, r.dot1q_en};
                default: HRDATA_OUT = 32'h00000000;
            endcase
        end
    end

    assign HREADYOUT_OUT = 1'b1;
    assign HRESP_OUT = 1'b0;
    assign FRM_RESULT_VALID_OUT = r.res_valid;
    assign FRM_EGRESS_MAP_OUT = r.res_egress;
    assign FRM_STRIP_MAP_OUT = r.res_strip;
    assign FRM_STP_SEL_OUT = r.res_stp;
    assign FRM_METER_EN_OUT = r.res_meter_en;
    assign FRM_METER_BKT_OUT = r.res_meter_bkt;

    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (!RST_B_IN);

    sequence seq_read_start;
        r.st == vlef_pkg::VLEF_IDLE && r.start && r.op == `VLEF_OP_READ;
    endsequence
    sequence seq_read_done;
        ##1 r.st == vlef_pkg::VLEF_RDWAIT ##1 (r.st == vlef_pkg::VLEF_IDLE && !r.start);
    endsequence

    AST_LATENCY: assert property (FRM_VALID_IN |-> ##2 FRM_RESULT_VALID_OUT)
        else $error("lookup result not two cycles after request");
    AST_STP_SEL: assert property (r.f1_valid |=>
        FRM_STP_SEL_OUT == $past(tbl_b_rdata[20:18]))
        else $error("spanning tree select not from entry");
    AST_STRIP_RES: assert property (FRM_RESULT_VALID_OUT |-> FRM_STRIP_MAP_OUT[7:6] == 2'h0)
        else $error("strip map reserved bits set");
    AST_STRIP_SUBSET: assert property (FRM_RESULT_VALID_OUT |->
        (FRM_STRIP_MAP_OUT & ~FRM_EGRESS_MAP_OUT) == 9'h000)
        else $error("strip on a non egress port");
    AST_MGMT_TAGGED: assert property (FRM_RESULT_VALID_OUT && $past(r.dot1q_en) |->
        !FRM_STRIP_MAP_OUT[8])
        else $error("management port egress untagged");
    AST_MEMBER_ONLY: assert property (FRM_RESULT_VALID_OUT && r.res_tagged |->
        (FRM_EGRESS_MAP_OUT & ~r.res_member) == 9'h000)
        else $error("tagged frame to non member port");
    AST_EGRESS_RES: assert property (FRM_RESULT_VALID_OUT |-> FRM_EGRESS_MAP_OUT[7:6] == 2'h0)
        else $error("egress reserved bits set");
    AST_READ_LOAD: assert property (seq_read_start |-> seq_read_done)
        else $error("table read did not finish in two cycles");
    AST_CLEAR_END: assert property (r.st == vlef_pkg::VLEF_CLEAR && r.clr_idx == 12'hFFF |=>
        r.st == vlef_pkg::VLEF_IDLE && !busy)
        else $error("clear sweep did not end at last entry");
    AST_EXCL_INGRESS: assert property (r.f1_valid && r.f1_tagged && tbl_b_rdata[21] |=>
        !FRM_EGRESS_MAP_OUT[$past(r.f1_ingress)])
        else $error("membership forwarding sent back to ingress");
    AST_METER: assert property (FRM_RESULT_VALID_OUT && !FRM_METER_EN_OUT |->
        !FRM_METER_BKT_OUT)
        else $error("bucket chosen with policing off");
endmodule : vlef_top
`default_nettype wire

// ---- logic/vlef_defs.svh ----
// Constants of the VLAN entry egress filter: register indices, entry fields, op codes.
// Assumes an includer that uses the macros; holds definitions only.
// Overview of operation
// - Spanning tree select picks one of eight
// - Tag strip mask bits 17..9, management top
// - Strip-mask bit set means untagged egress
// - Management port egress stays tagged under 802.1Q
// - Tagged frames egress only on member ports
// - Member mask bit 8 management, 7:6 reserved
// - Twelve-bit index register selects table entry
// - Op codes write, read, clear; 11 reserved
// - Forwarding basis: membership minus ingress, else lookup
// - Meter enable applies chosen bucket policing
`ifndef VLEF_DEFS_SVH
`define VLEF_DEFS_SVH

// Register indices; byte address is four times the index
`define VLEF_IDX_OP 8'h80
`define VLEF_IDX_INDEX 8'h81
`define VLEF_IDX_ENTRY 8'h83
`define VLEF_IDX_CTRL 8'h90

`define VLEF_OP_START_BIT 7
`define VLEF_OP_WRITE 2'h0
`define VLEF_OP_READ 2'h1
`define VLEF_OP_CLEAR 2'h2

`define VLEF_ENT_BKT_BIT 23
`define VLEF_ENT_METER_BIT 22
`define VLEF_ENT_BASIS_BIT 21
`define VLEF_ENT_STP_HI 20
`define VLEF_ENT_STP_LO 18
`define VLEF_ENT_STRIP_HI 17
`define VLEF_ENT_STRIP_LO 9
`define VLEF_ENT_MEMBER_HI 8
`define VLEF_ENT_MEMBER_LO 0

// Ports 5..0 and the management port (bit 8); bits 7:6 reserved
`define VLEF_PORT_VALID 9'h13F
`define VLEF_MGMT_BIT 8

`define VLEF_TBL_LAST 12'hFFF
`define VLEF_ENTRY_RESET 24'h000000

`endif

// ---- logic/vlef_pkg.sv ----
// Types of the VLAN entry egress filter.
// Assumes vlef_defs.svh for the numbers.
package vlef_pkg;

    typedef enum logic [1:0] {
        VLEF_IDLE = 2'b00,
        VLEF_RDWAIT = 2'b01,
        VLEF_CLEAR = 2'b11
    } vlef_state_t;

    typedef struct packed {
        vlef_state_t st;
        logic [1:0] op;
        logic start;
        logic [11:0] index;
        logic [23:0] entry;
        logic [11:0] clr_idx;
        logic dot1q_en;
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_idx;
        logic ap_hit;
        logic f1_valid;
        logic f1_tagged;
        logic [8:0] f1_lookup;
        logic [3:0] f1_ingress;
        logic res_valid;
        logic res_tagged;
        logic [8:0] res_member;
        logic [8:0] res_egress;
        logic [8:0] res_strip;
        logic [2:0] res_stp;
        logic res_meter_en;
        logic res_meter_bkt;
    } vlef_regs_t;

    typedef struct packed {
        logic [23:0] a_rdata;
        logic [23:0] b_rdata;
    } vlef_tbl_regs_t;

endpackage : vlef_pkg

// ---- logic/vlef_table.sv ----
// VLAN table store: 4096 entries, one software port and one frame lookup port.
// Assumes one clock; read data appear one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
module vlef_table (
    input wire logic clk_in,           // Core clock
    input wire logic rst_b_in,         // Async reset, active low
    input wire logic a_we_in,          // Software port write
    input wire logic [11:0] a_addr_in, // Software port address
    input wire logic [23:0] a_wdata_in, // Software port write data
    output logic [23:0] a_rdata_out,   // Software port read data
    input wire logic [11:0] b_addr_in, // Lookup port address
    output logic [23:0] b_rdata_out    // Lookup port read data
);
    logic [23:0] mem [0:4095];
    vlef_pkg::vlef_tbl_regs_t r;
    vlef_pkg::vlef_tbl_regs_t next_r;

    always_ff @(posedge clk_in) begin
        if (a_we_in) begin
            mem[a_addr_in] <= a_wdata_in;
        end
    end

    always_comb begin
        next_r = r;
        next_r.a_rdata = mem[a_addr_in];
        next_r.b_rdata = mem[b_addr_in];
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign a_rdata_out = r.a_rdata;
    assign b_rdata_out = r.b_rdata;
endmodule : vlef_table
`default_nettype wire

// ---- verif/vlef_frame_src.sv ----
// Frame forwarding pipeline model: issues one lookup request and collects its result.
// Assumes the filter answers two cycles after the request edge.
`timescale 1ns/1ps
`default_nettype none
module vlef_frame_src (
    input wire logic clk_in,          // Core clock
    output logic valid_out,           // Lookup request
    output logic [11:0] vid_out,      // VLAN id
    output logic tagged_out,          // Frame tagged
    output logic [8:0] lookup_out,    // Address lookup map
    output logic [3:0] ingress_out,   // Ingress port
    input wire logic res_valid_in,    // Result pulse
    input wire logic [8:0] egress_in, // Allowed egress
    input wire logic [8:0] strip_in,  // Strip map
    input wire logic [2:0] stp_in,    // Spanning tree
    input wire logic meter_en_in,     // Policing enable
    input wire logic meter_bkt_in     // Policing bucket
);
    initial begin
        valid_out = 1'h0;
        vid_out = 12'h0;
        tagged_out = 1'h0;
        lookup_out = 9'h0;
        ingress_out = 4'h0;
    end

    task automatic send(input logic [11:0] vid, input logic tg, input logic [8:0] lk,
                        input logic [3:0] ing, output logic [24:0] res);
        logic early;
        @(posedge clk_in);
        valid_out <= 1'h1;
        vid_out <= vid;
        tagged_out <= tg;
        lookup_out <= lk;
        ingress_out <= ing;
        @(posedge clk_in);
        // Qualifiers are meaningless once taken, so they are scrambled
        valid_out <= 1'h0;
        vid_out <= ~vid;
        tagged_out <= ~tg;
        lookup_out <= ~lk;
        ingress_out <= ~ing;
        // Result must still be low one cycle after the request edge
        #1 early = res_valid_in;
        @(posedge clk_in);
        #1 res = {early, res_valid_in, egress_in, strip_in, stp_in, meter_en_in, meter_bkt_in};
    endtask : send
endmodule : vlef_frame_src
`default_nettype wire

// ---- verif/test_vlef_top.sv ----
// Self-checking bench of the VLAN entry egress filter: registers, table ops, frame decisions.
// Assumes the zero-wait AHB-Lite slave and the frame source model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "vlef_defs.svh"
module test_vlef_top;
    logic CORE_CLK_IN, RST_B_IN, HSEL_IN, HWRITE_IN, HRESP_OUT, HREADYOUT_OUT;
    logic [31:0] HADDR_IN, HWDATA_IN, HRDATA_OUT;
    logic [1:0] HTRANS_IN;
    logic [2:0] HSIZE_IN, FRM_STP_SEL_OUT;
    logic FRM_VALID_IN, FRM_TAGGED_IN, FRM_RESULT_VALID_OUT, FRM_METER_EN_OUT, FRM_METER_BKT_OUT;
    logic [11:0] FRM_VID_IN;
    logic [8:0] FRM_LOOKUP_MAP_IN, FRM_EGRESS_MAP_OUT, FRM_STRIP_MAP_OUT;
    logic [3:0] FRM_INGRESS_IN;
    wire logic HREADY_IN;
    int err_total;
    int samples_checked;
    localparam logic [23:0] ENT_A = {1'h1, 1'h1, 1'h0, 3'h5, 9'h02A, 9'h1FF};
    localparam logic [23:0] ENT_B = {1'h1, 1'h0, 1'h1, 3'h2, 9'h13F, 9'h13F};

    assign HREADY_IN = HREADYOUT_OUT;

    vlef_top dut (.CORE_CLK_IN(CORE_CLK_IN), .RST_B_IN(RST_B_IN), .HSEL_IN(HSEL_IN),
        .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HSIZE_IN(HSIZE_IN),
        .HWDATA_IN(HWDATA_IN), .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT),
        .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT), .FRM_VALID_IN(FRM_VALID_IN),
        .FRM_VID_IN(FRM_VID_IN), .FRM_TAGGED_IN(FRM_TAGGED_IN),
        .FRM_LOOKUP_MAP_IN(FRM_LOOKUP_MAP_IN), .FRM_INGRESS_IN(FRM_INGRESS_IN),
        .FRM_RESULT_VALID_OUT(FRM_RESULT_VALID_OUT), .FRM_EGRESS_MAP_OUT(FRM_EGRESS_MAP_OUT),
        .FRM_STRIP_MAP_OUT(FRM_STRIP_MAP_OUT), .FRM_STP_SEL_OUT(FRM_STP_SEL_OUT),
        .FRM_METER_EN_OUT(FRM_METER_EN_OUT), .FRM_METER_BKT_OUT(FRM_METER_BKT_OUT));

    vlef_frame_src src (.clk_in(CORE_CLK_IN), .valid_out(FRM_VALID_IN), .vid_out(FRM_VID_IN),
        .tagged_out(FRM_TAGGED_IN), .lookup_out(FRM_LOOKUP_MAP_IN), .ingress_out(FRM_INGRESS_IN),
        .res_valid_in(FRM_RESULT_VALID_OUT), .egress_in(FRM_EGRESS_MAP_OUT),
        .strip_in(FRM_STRIP_MAP_OUT), .stp_in(FRM_STP_SEL_OUT), .meter_en_in(FRM_METER_EN_OUT),
        .meter_bkt_in(FRM_METER_BKT_OUT));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude

    task automatic ahb_addr(input logic [7:0] idx, input logic wr);
        @(posedge CORE_CLK_IN);
        HSEL_IN <= 1'h1;
        HTRANS_IN <= 2'h2;
        HWRITE_IN <= wr;
        HADDR_IN <= {22'h0, idx, 2'h0};
        do @(posedge CORE_CLK_IN); while (HREADY_IN !== 1'h1);
        HTRANS_IN <= 2'h0;
    endtask : ahb_addr

    task automatic ahb_wr(input logic [7:0] idx, input logic [31:0] d);
        ahb_addr(idx, 1'h1);
        HWDATA_IN <= d;
        do @(posedge CORE_CLK_IN); while (HREADY_IN !== 1'h1);
    endtask : ahb_wr

    task automatic ahb_rd(input logic [7:0] idx, output logic [31:0] d);
        ahb_addr(idx, 1'h0);
        do @(posedge CORE_CLK_IN); while (HREADY_IN !== 1'h1);
        d = HRDATA_OUT;
    endtask : ahb_rd

    // Starts a table op and polls busy; returns the number of polls
    task automatic op_run(input logic [1:0] code, input logic [11:0] idx, output int n);
        logic [31:0] d;
        ahb_wr(`VLEF_IDX_INDEX, {20'h0, idx});
        ahb_wr(`VLEF_IDX_OP, {24'h0, 1'h1, 5'h0, code});
        n = 0;
        do begin
            ahb_rd(`VLEF_IDX_OP, d);
            n++;
        end while (d[7] === 1'h1);
        check("op_done", d, {30'h0, code});
    endtask : op_run

    task automatic frame(input logic [11:0] vid, input logic tg, input logic [8:0] lk,
                         input logic [3:0] ing, input logic [24:0] exp);
        logic [24:0] res;
        src.send(vid, tg, lk, ing, res);
        check("frame", {7'h0, res}, {7'h0, exp});
    endtask : frame

    task automatic t_regs();
        logic [31:0] d;
        ahb_rd(`VLEF_IDX_INDEX, d);
        check("index_reset", d, 32'h0);
        ahb_wr(`VLEF_IDX_INDEX, 32'hFFFFFFFF);
        ahb_rd(`VLEF_IDX_INDEX, d);
        check("index_width", d, 32'h00000FFF);
        ahb_wr(`VLEF_IDX_ENTRY, 32'hFFFFFFFF);
        ahb_rd(`VLEF_IDX_ENTRY, d);
        check("entry_width", d, 32'h00FFFFFF);
        ahb_wr(8'h82, 32'h5);
        ahb_rd(8'h82, d);
        check("unmapped", d, 32'h0);
    endtask : t_regs

    task automatic t_clear();
        logic [31:0] d;
        int n;
        op_run(`VLEF_OP_CLEAR, 12'h5, n);
        check("clear_span", 32'(n > 1360 && n < 1372), 32'h1);
        ahb_wr(`VLEF_IDX_ENTRY, 32'h00ABCDEF);
        op_run(`VLEF_OP_READ, 12'h5, n);
        ahb_rd(`VLEF_IDX_ENTRY, d);
        check("cleared", d, 32'h0);
        frame(12'h5, 1'h1, 9'h13F, 4'h0, {2'h1, 23'h0});
    endtask : t_clear

    task automatic t_write_read();
        logic [31:0] d;
        int n;
        ahb_wr(`VLEF_IDX_ENTRY, {8'h0, ENT_A});
        op_run(`VLEF_OP_WRITE, 12'hFFF, n);
        ahb_wr(`VLEF_IDX_ENTRY, {8'h0, ENT_B});
        op_run(`VLEF_OP_WRITE, 12'h7, n);
        op_run(`VLEF_OP_READ, 12'hFFF, n);
        ahb_rd(`VLEF_IDX_ENTRY, d);
        check("readback", d, {8'h0, ENT_A});
    endtask : t_write_read

    task automatic t_frames();
        frame(12'hFFF, 1'h1, 9'h1C3, 4'h0, {2'h1, 9'h103, 9'h002, 3'h5, 2'h3});
        frame(12'hFFF, 1'h0, 9'h1FF, 4'h1, {2'h1, 9'h13F, 9'h000, 3'h5, 2'h3});
        frame(12'h7, 1'h1, 9'h001, 4'h3, {2'h1, 9'h137, 9'h137, 3'h2, 2'h0});
        ahb_wr(`VLEF_IDX_CTRL, 32'h1);
        frame(12'h7, 1'h1, 9'h001, 4'h3, {2'h1, 9'h137, 9'h037, 3'h2, 2'h0});
        frame(12'h7, 1'h1, 9'h000, 4'h8, {2'h1, 9'h03F, 9'h03F, 3'h2, 2'h0});
    endtask : t_frames

    task automatic t_reserved();
        logic [31:0] d;
        int n;
        ahb_wr(`VLEF_IDX_ENTRY, 32'h00123456);
        op_run(2'h3, 12'h7, n);
        op_run(`VLEF_OP_READ, 12'h7, n);
        ahb_rd(`VLEF_IDX_ENTRY, d);
        check("reserved_op", d, {8'h0, ENT_B});
    endtask : t_reserved

    initial begin
        CORE_CLK_IN = 1'h0;
        forever #25 CORE_CLK_IN = ~CORE_CLK_IN;
    end

    initial begin
        err_total = 0;
        samples_checked = 0;
        RST_B_IN = 1'h0;
        HSEL_IN = 1'h0;
        HADDR_IN = 32'h0;
        HTRANS_IN = 2'h0;
        HWRITE_IN = 1'h0;
        HSIZE_IN = 3'h2;
        HWDATA_IN = 32'h0;
        repeat (8) @(posedge CORE_CLK_IN);
        RST_B_IN <= 1'h1;
        t_regs();
        t_clear();
        t_write_read();
        t_frames();
        t_reserved();
        conclude();
    end

    initial begin
        repeat (20000) @(posedge CORE_CLK_IN);
        err_total++;
        conclude();
    end
endmodule : test_vlef_top
`default_nettype wire
